/* File: pkg/vector_map_defines.svh */
// Offsets, field positions, reset values and vector addresses of the vector map.
`ifndef VECTOR_MAP_DEFINES_SVH
`define VECTOR_MAP_DEFINES_SVH

`define VEC_ADDR_W 13
`define BOOT_RESET_ADDR_DEF 13'h1C00
`define UNLOCK_CYCLES 4

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_BOOT_INFO 8'h0C
`define OFF_LAST_VEC 8'h10

`define CTRL_UNLOCK_BIT 0
`define CTRL_SELECT_BIT 1
`define BOOT_FUSE_BIT 16
`define LAST_BAD_BIT 31

`define EV_MOVED_BIT 0
`define EV_EXPIRED_BIT 1
`define EV_BADNUM_BIT 2
`define EV_W 3

`define CTRL_RESET 2'h0
`define STATUS_RESET 3'h0
`define MASK_RESET 3'h0

`define VA_RESET 8'h00
`define VA_EXT_REQ0 8'h02
`define VA_EXT_REQ1 8'h04
`define VA_T2_CMP 8'h06
`define VA_T2_OVF 8'h08
`define VA_T1_CAP 8'h0A
`define VA_T1_CMPA 8'h0C
`define VA_T1_CMPB 8'h0E
`define VA_T1_OVF 8'h10
`define VA_T0_OVF 8'h12
`define VA_SPI_DONE 8'h14
`define VA_USART_RX 8'h16
`define VA_USART_EMPTY 8'h18
`define VA_USART_TX 8'h1A
`define VA_CONV_DONE 8'h1C
`define VA_EEPROM_RDY 8'h1E
`define VA_ANALOG_CMP 8'h20
`define VA_TWO_WIRE 8'h22
`define VA_EXT_REQ2 8'h24
`define VA_T0_CMP 8'h26
`define VA_STORE_RDY 8'h28

`endif

/* File: pkg/vector_map_pkg.sv */
// Types shared by the vector map and its address calculator.
`include "vector_map_defines.svh"

package vector_map_pkg;

  typedef logic [4:0] vector_num_t;
  typedef logic [`VEC_ADDR_W-1:0] prog_addr_t;

  typedef enum logic [4:0] {
    VN_RESET = 5'h01, VN_EXT_REQ0 = 5'h02, VN_EXT_REQ1 = 5'h03,
    VN_T2_CMP = 5'h04, VN_T2_OVF = 5'h05, VN_T1_CAP = 5'h06,
    VN_T1_CMPA = 5'h07, VN_T1_CMPB = 5'h08, VN_T1_OVF = 5'h09,
    VN_T0_OVF = 5'h0A, VN_SPI_DONE = 5'h0B, VN_USART_RX = 5'h0C,
    VN_USART_EMPTY = 5'h0D, VN_USART_TX = 5'h0E, VN_CONV_DONE = 5'h0F,
    VN_EEPROM_RDY = 5'h10, VN_ANALOG_CMP = 5'h11, VN_TWO_WIRE = 5'h12,
    VN_EXT_REQ2 = 5'h13, VN_T0_CMP = 5'h14, VN_STORE_RDY = 5'h15
  } vector_id_e;

  typedef enum logic [2:0] {
    ST_LOCKED = 3'b001,
    ST_OPEN = 3'b010,
    ST_HOLD = 3'b100
  } unlock_state_e;

  typedef struct packed {
    logic req;
    vector_num_t num;
  } vec_req_s;

  typedef struct packed {
    logic valid;
    logic bad;
    prog_addr_t addr;
  } vec_rsp_s;

endpackage

/* File: hdl/vector_addr_calc.sv */
// Combinational mapping of a vector number to its program address.
`timescale 1ns/1ps

module vector_addr_calc
  import vector_map_pkg::*;
(
  // Placement controls
  input wire logic table_select,
  input wire logic fuse_programmed,
  input wire prog_addr_t boot_addr,
  // Lookup
  input wire vector_num_t num,
  output prog_addr_t addr,
  output logic bad
);

  function automatic logic [8:0] default_offset(input vector_num_t n);
    logic [8:0] r;
    r = 9'h100;
    case (n)
      VN_RESET: r = {1'b0, `VA_RESET};
      VN_EXT_REQ0: r = {1'b0, `VA_EXT_REQ0};
      VN_EXT_REQ1: r = {1'b0, `VA_EXT_REQ1};
      VN_EXT_REQ2: r = {1'b0, `VA_EXT_REQ2};
      VN_T2_CMP: r = {1'b0, `VA_T2_CMP};
      VN_T2_OVF: r = {1'b0, `VA_T2_OVF};
      VN_T1_CAP: r = {1'b0, `VA_T1_CAP};
      VN_T1_CMPA: r = {1'b0, `VA_T1_CMPA};
      VN_T1_CMPB: r = {1'b0, `VA_T1_CMPB};
      VN_T1_OVF: r = {1'b0, `VA_T1_OVF};
      VN_T0_OVF: r = {1'b0, `VA_T0_OVF};
      VN_T0_CMP: r = {1'b0, `VA_T0_CMP};
      VN_SPI_DONE: r = {1'b0, `VA_SPI_DONE};
      VN_USART_RX: r = {1'b0, `VA_USART_RX};
      VN_USART_EMPTY: r = {1'b0, `VA_USART_EMPTY};
      VN_USART_TX: r = {1'b0, `VA_USART_TX};
      VN_TWO_WIRE: r = {1'b0, `VA_TWO_WIRE};
      VN_CONV_DONE: r = {1'b0, `VA_CONV_DONE};
      VN_EEPROM_RDY: r = {1'b0, `VA_EEPROM_RDY};
      VN_ANALOG_CMP: r = {1'b0, `VA_ANALOG_CMP};
      VN_STORE_RDY: r = {1'b0, `VA_STORE_RDY};
      default: r = 9'h100;
    endcase
    return r;
  endfunction

  logic [8:0] off;
  prog_addr_t base;

  // The reset entry follows the fuse, every other entry follows the select bit.
  always_comb begin
    off = default_offset(num);
    bad = off[8];
    if (num == VN_RESET) begin
      base = fuse_programmed ? boot_addr : '0;
    end else begin
      base = table_select ? boot_addr : '0;
    end
    addr = base + {{(`VEC_ADDR_W-8){1'b0}}, off[7:0]};
  end

endmodule

/* File: hdl/vector_map_top.sv */
// Reset and interrupt vector map with table relocation, behind an AXI4-Lite slave.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module vector_map_top
  import vector_map_pkg::*;
#(
  parameter prog_addr_t BOOT_RESET_ADDR = `BOOT_RESET_ADDR_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fuse strap
  input wire logic boot_reset_select_fuse,
  // Core side
  input wire vec_req_s vec_req,
  input wire logic instr_done,
  output vec_rsp_s vec_rsp,
  output prog_addr_t reset_vector_addr,
  output logic irq_block,
  // Interrupt
  output logic irq
);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] UNLOCK_LOAD = 2'(`UNLOCK_CYCLES - 1);

  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == `OFF_CTRL) || (w == `OFF_STATUS) || (w == `OFF_MASK) ||
           (w == `OFF_BOOT_INFO) || (w == `OFF_LAST_VEC);
  endfunction

  // Bus state.
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Block state.
  unlock_state_e state_reg;
  unlock_state_e state_next;
  logic [1:0] unlock_cnt_reg;
  logic select_reg;
  logic fuse_reg;
  logic fuse_cap_reg;
  logic [`EV_W-1:0] status_reg;
  logic [`EV_W-1:0] status_next;
  logic [`EV_W-1:0] mask_reg;
  logic [`EV_W-1:0] events;
  logic irq_reg;
  logic irq_block_reg;
  vec_rsp_s vec_rsp_reg;
  prog_addr_t reset_vec_reg;

  logic aw_take;
  logic w_take;
  logic do_write;
  logic aw_hold_next;
  logic w_hold_next;
  logic bvalid_next;
  logic ar_take;
  logic rvalid_next;
  logic wr_lane0;
  logic ctrl_wr;
  logic wr_unlock;
  logic wr_select;
  logic fuse_programmed;
  prog_addr_t calc_addr;
  logic calc_bad;

  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign do_write = aw_hold_reg && w_hold_reg;
  assign aw_hold_next = (aw_hold_reg || aw_take) && !do_write;
  assign w_hold_next = (w_hold_reg || w_take) && !do_write;
  assign bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
  assign ar_take = s_axi_arvalid && arready_reg;
  assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

  assign wr_lane0 = do_write && wstrb_reg[0];
  assign ctrl_wr = wr_lane0 && ({awaddr_reg[7:2], 2'b00} == `OFF_CTRL);
  assign wr_unlock = wdata_reg[`CTRL_UNLOCK_BIT];
  assign wr_select = wdata_reg[`CTRL_SELECT_BIT];

  // A fuse reading of zero is the programmed state.
  assign fuse_programmed = !fuse_reg;

  // Address and data may arrive in either order; each is held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      awready_reg <= !aw_hold_next && !bvalid_next;
      wready_reg <= !w_hold_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rresp_reg <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          `OFF_CTRL: rdata_reg <= {30'h0, select_reg, state_reg == ST_OPEN};
          `OFF_STATUS: rdata_reg <= {29'h0, status_reg};
          `OFF_MASK: rdata_reg <= {29'h0, mask_reg};
          `OFF_BOOT_INFO: rdata_reg <= {15'h0, fuse_programmed, 3'h0, BOOT_RESET_ADDR};
          `OFF_LAST_VEC: rdata_reg <= {vec_rsp_reg.bad, 18'h0, vec_rsp_reg.addr};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // The strap is caught once, in the first cycle after reset is released.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_reg <= 1'b1;
      fuse_cap_reg <= 1'b0;
    end else if (!fuse_cap_reg) begin
      fuse_reg <= boot_reset_select_fuse;
      fuse_cap_reg <= 1'b1;
    end
  end

  // Unlock sequencing: the select bit only moves through the open window.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKED: begin
        if (ctrl_wr && wr_unlock) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (ctrl_wr && !wr_unlock) begin
          state_next = ST_HOLD;
        end else if (ctrl_wr && wr_unlock) begin
          state_next = ST_OPEN;
        end else if (unlock_cnt_reg == 2'h0) begin
          state_next = ST_LOCKED;
        end
      end
      ST_HOLD: begin
        if (ctrl_wr && wr_unlock) begin
          state_next = ST_OPEN;
        end else if (instr_done) begin
          state_next = ST_LOCKED;
        end
      end
      default: state_next = ST_LOCKED;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_LOCKED;
      unlock_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (ctrl_wr && wr_unlock) begin
        unlock_cnt_reg <= UNLOCK_LOAD;
      end else if (state_reg == ST_OPEN && unlock_cnt_reg != 2'h0) begin
        unlock_cnt_reg <= unlock_cnt_reg - 2'h1;
      end
    end
  end

  // A select write outside the open window is dropped, guarding against stray stores.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_reg <= 1'(`CTRL_RESET >> `CTRL_SELECT_BIT);
    end else if (state_reg == ST_OPEN && ctrl_wr && !wr_unlock) begin
      select_reg <= wr_select;
    end
  end

  // Interrupt blocking is a separate line; the core's global enable is left alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_block_reg <= 1'b0;
    end else begin
      irq_block_reg <= state_next != ST_LOCKED;
    end
  end

  always_comb begin
    events = '0;
    events[`EV_MOVED_BIT] = state_reg == ST_OPEN && ctrl_wr && !wr_unlock && wr_select != select_reg;
    events[`EV_EXPIRED_BIT] = state_reg == ST_OPEN && !ctrl_wr && unlock_cnt_reg == 2'h0;
    events[`EV_BADNUM_BIT] = vec_req.req && calc_bad;
  end

  // Setting wins over a write-one-to-clear in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (wr_lane0 && {awaddr_reg[7:2], 2'b00} == `OFF_STATUS) begin
      status_next = status_reg & ~wdata_reg[`EV_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= `STATUS_RESET;
      mask_reg <= `MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (wr_lane0 && {awaddr_reg[7:2], 2'b00} == `OFF_MASK) begin
        mask_reg <= wdata_reg[`EV_W-1:0];
      end
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  vector_addr_calc u_calc (
    .table_select(select_reg),
    .fuse_programmed(fuse_programmed),
    .boot_addr(BOOT_RESET_ADDR),
    .num(vec_req.num),
    .addr(calc_addr),
    .bad(calc_bad)
  );

  // Vector lookups answer on the edge after the request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_rsp_reg <= '0;
      reset_vec_reg <= '0;
    end else begin
      vec_rsp_reg.valid <= vec_req.req;
      if (vec_req.req) begin
        vec_rsp_reg.bad <= calc_bad;
        vec_rsp_reg.addr <= calc_bad ? '0 : calc_addr;
      end
      reset_vec_reg <= fuse_programmed ? BOOT_RESET_ADDR : '0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign vec_rsp = vec_rsp_reg;
  assign reset_vector_addr = reset_vec_reg;
  assign irq_block = irq_block_reg;
  assign irq = irq_reg;

endmodule

/* File: testbench/vector_map_properties.sv */
// Port-level assertions for the vector map.
`timescale 1ns/1ps
`include "vector_map_defines.svh"

module vector_map_properties
  import vector_map_pkg::*;
#(
  parameter prog_addr_t BOOT_RESET_ADDR = `BOOT_RESET_ADDR_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Vector side
  input wire logic boot_reset_select_fuse,
  input wire vec_req_s vec_req,
  input wire vec_rsp_s vec_rsp,
  input wire prog_addr_t reset_vector_addr
);
  prog_addr_t off_reg;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // The offset is delayed one cycle so that it lines up with the registered answer.
  always_ff @(posedge aclk) begin
    off_reg <= {7'h00, vec_req.num - 5'h01, 1'b0};
  end

  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence irq_lookup;
    vec_req.req && vec_req.num inside {[5'h02:5'h15]};
  endsequence

  lookup_answer_a: assert property (vec_req.req |=> vec_rsp.valid)
    else $error("lookup not answered");
  lookup_quiet_a: assert property (!vec_req.req |=> !vec_rsp.valid && $stable(vec_rsp.addr))
    else $error("answer without lookup");
  int_vector_a: assert property (irq_lookup |=> !vec_rsp.bad &&
    (vec_rsp.addr == off_reg || vec_rsp.addr == BOOT_RESET_ADDR + off_reg))
    else $error("interrupt vector address wrong");
  bad_number_a: assert property (vec_req.req && vec_req.num > 5'h15 |=> vec_rsp.bad && vec_rsp.addr == '0)
    else $error("out of range number accepted");
  reset_entry_a: assert property (vec_req.req && vec_req.num == 5'h01 |=> vec_rsp.addr == reset_vector_addr)
    else $error("reset entry differs");
  reset_place_a: assert property ($past(aresetn) && $past(aresetn, 2) |->
    reset_vector_addr == (boot_reset_select_fuse ? '0 : BOOT_RESET_ADDR))
    else $error("reset address does not follow fuse");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

bind vector_map_top vector_map_properties #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) vector_map_properties_inst (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .boot_reset_select_fuse, .vec_req, .vec_rsp, .reset_vector_addr
);

/* File: testbench/core_model.sv */
// Behavioural processor core that fetches vectors and retires instructions.
`timescale 1ns/1ps

module core_model
  import vector_map_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Vector fetch
  output vec_req_s vec_req,
  input wire vec_rsp_s vec_rsp,
  // Retirement
  output logic instr_done
);
  initial begin
    vec_req = '0;
    instr_done = 1'b0;
  end

  // Between fetches the number bus shows the inverse so a stale number is never reused.
  task automatic look(input vector_num_t n, output logic v, output logic b, output prog_addr_t a);
    vec_req <= '{req: 1'b1, num: n};
    @(posedge aclk);
    vec_req <= '{req: 1'b0, num: ~n};
    @(posedge aclk);
    v = vec_rsp.valid;
    b = vec_rsp.bad;
    a = vec_rsp.addr;
  endtask

  task automatic retire();
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
  endtask
endmodule

/* File: testbench/reset_interrupt_vector_map_bench.sv */
// Self-checking bench for the reset and interrupt vector map.
`timescale 1ns/1ps
`include "vector_map_defines.svh"

module reset_interrupt_vector_map_bench;
  import vector_map_pkg::*;
  localparam prog_addr_t BOOT = 13'h1C00;
  logic aclk, aresetn, boot_reset_select_fuse, instr_done, irq_block, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bready, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic late_ready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  vec_req_s vec_req;
  vec_rsp_s vec_rsp;
  prog_addr_t reset_vector_addr;
  int bad_count, n_checks;

  vector_map_top #(.BOOT_RESET_ADDR(BOOT)) vector_map_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_reset_select_fuse,
    .vec_req, .instr_done, .vec_rsp, .reset_vector_addr, .irq_block, .irq
  );
  core_model core_model_inst (.aclk, .vec_req, .vec_rsp, .instr_done);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Response ready normally stays high; with late_ready it is raised only once the answer shows,
  // so the slave must hold its answer. Only the watchdog ends a wait.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (late_ready) begin
      s_axi_bready <= 1'b0;
    end
    do begin
      @(posedge aclk);
    end while (s_axi_bvalid !== 1'b1);
    if (late_ready) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if (late_ready) begin
      s_axi_rready <= 1'b0;
    end
    do begin
      @(posedge aclk);
    end while (s_axi_rvalid !== 1'b1);
    if (late_ready) begin
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    chk(s_axi_rdata, ed, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask

  task automatic vchk(input vector_num_t n, input prog_addr_t ea, input logic eb);
    logic v, b;
    prog_addr_t a;
    core_model_inst.look(n, v, b, a);
    chk(32'(v), 32'h1, "valid");
    chk(32'(b), 32'(eb), "bad");
    chk(32'(a), 32'(ea), "addr");
  endtask

  task automatic table_chk(input prog_addr_t base);
    for (int n = 2; n <= 21; n++) begin
      vchk(vector_num_t'(n), base + prog_addr_t'(2 * (n - 1)), 1'b0);
    end
  endtask

  task automatic do_reset(input logic f);
    aresetn <= 1'b0;
    boot_reset_select_fuse <= f;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    boot_reset_select_fuse = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hF;
    late_ready = 1'b0;
    do_reset(1'b1);
    chk(32'(reset_vector_addr), 32'h0, "reset address");
    rd(`OFF_CTRL, 32'h0, 2'h0);
    rd(`OFF_BOOT_INFO, {15'h0, 1'b0, 3'h0, BOOT}, 2'h0);
    vchk(5'h01, 13'h0000, 1'b0);
    table_chk(13'h0000);
    vchk(5'h00, 13'h0000, 1'b1);
    vchk(5'h16, 13'h0000, 1'b1);
    $display("test map done");
    chk(32'(irq), 32'h0, "masked irq");
    wr(`OFF_MASK, 32'h7, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1, "irq");
    wr(`OFF_STATUS, 32'h4, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0, "cleared irq");
    rd(`OFF_MASK, 32'h7, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(`OFF_MASK, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`OFF_MASK, 32'h7, 2'h0);
    $display("test irq done");
    wr(`OFF_CTRL, 32'h1, 2'h0);
    chk(32'(irq_block), 32'h1, "block open");
    wr(`OFF_CTRL, 32'h2, 2'h0);
    chk(32'(irq_block), 32'h1, "block hold");
    core_model_inst.retire();
    @(posedge aclk);
    chk(32'(irq_block), 32'h0, "block released");
    rd(`OFF_CTRL, 32'h2, 2'h0);
    table_chk(BOOT);
    vchk(5'h01, 13'h0000, 1'b0);
    rd(`OFF_STATUS, 32'h1, 2'h0);
    chk(32'(irq), 32'h1, "moved irq");
    wr(`OFF_STATUS, 32'h1, 2'h0);
    $display("test unlock done");
    wr(`OFF_CTRL, 32'h1, 2'h0);
    repeat (8) @(posedge aclk);
    chk(32'(irq_block), 32'h0, "block expired");
    rd(`OFF_STATUS, 32'h2, 2'h0);
    wr(`OFF_CTRL, 32'h0, 2'h0);
    vchk(5'h02, BOOT + 13'h0002, 1'b0);
    rd(`OFF_LAST_VEC, {19'h0, BOOT + 13'h0002}, 2'h0);
    $display("test expire done");
    late_ready = 1'b1;
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    late_ready = 1'b0;
    $display("test bus done");
    do_reset(1'b0);
    chk(32'(reset_vector_addr), 32'(BOOT), "boot reset address");
    rd(`OFF_BOOT_INFO, {15'h0, 1'b1, 3'h0, BOOT}, 2'h0);
    vchk(5'h01, BOOT, 1'b0);
    vchk(5'h02, 13'h0002, 1'b0);
    $display("test fuse done");
    finish_test();
  end

  // The whole sequence needs a few hundred cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    finish_test();
  end
endmodule
